// ===== design/asc_top.sv
// Serial control-byte receiver, conversion sequencer and result shifter.
// Assumes a master driving SCLK_I idle low and CS_N_I; core side on CORE_CLK_I.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: with select low, each rising serial clock samples one data bit.
// RL2: leading zeros are skipped; the first one opens the control byte.
// RL3: eight bits MSB first: start, channel, polarity, input config, mode.
// RL4: mode 00 full power-down, 01 fast, 10 internal clock, 11 external.
// RL5: single-ended codes map to inputs 0,1..7 as listed, negative on common.
// RL6: differential codes pick pairs, low codes even-positive, high codes odd.
// RL7: only a completed control byte starts a conversion.
// RL8: a data line held high converts input seven unipolar, external clock.
// RL9: external mode raises the strobe one clock before the result MSB.
// RL10: with data held high and continuous clock, one conversion per 15 clocks.
// RL11: strobe and data output change only on falling serial clock.
// RL12: the master uses clock polarity zero and phase zero.
// RL13: the master makes the clock, between 100kHz and 2MHz; the bench master runs a 30 ns period instead.
// RL14: the master's first byte has start and both mode bits set.
// RL15: master lowers select, sends config, two zero bytes, raises select.
// RL16: a conversion needs only three byte transfers.
// RL17: result frame: one zero, ten bits, two sub-LSB bits, then zeros.
// RL18: the master finishes a conversion within 120us.
// RL19: unipolar gives straight binary, bipolar gives twos complement.
// RL20: result bits leave MSB first on falling clock edges.
// RL21: conversion begins on the fall after the last mode bit.
// RL22: data output floats while select is high.
// RL23: twelve decisions follow the strobe, one per falling edge.
// RL24: track after the fifth bit's fall, hold after the eighth.
// RL25: select rising clears the bit counter to hunt a new start bit.
module asc_top (
  // Core clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  // Serial link
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic DIN_I,
  output logic DOUT_O,
  output logic DOUT_OE_O,
  output logic STROBE_O,
  output logic STROBE_OE_O,
  // Analog front end, serial clock domain
  input wire logic COMP_I,
  output logic TRACK_O,
  output logic [11:0] DAC_CODE_O,
  // Decoded configuration, core domain
  output logic CFG_VALID_O,
  output logic [2:0] CHAN_POS_O,
  output logic [2:0] CHAN_NEG_O,
  output logic NEG_IS_COM_O,
  output logic UNIPOLAR_O,
  output logic [1:0] MODE_O,
  output logic FULL_PD_O,
  output logic FAST_PD_O,
  output logic EXT_CLK_O,
  // Result, core domain
  output logic RESULT_VALID_O,
  output logic [9:0] RESULT_O,
  output logic [1:0] SUB_LSB_O
);

  // Link domain state
  logic link_rst_n_meta;
  logic link_rst_n;
  logic [3:0] rx_cnt;
  logic [7:0] rx_shift;
  logic [3:0] step;
  asc_pkg::asc_phase_t phase;
  logic allow_start;
  logic byte_done;
  logic conv_end;
  logic [7:0] cfg_hold;
  logic cfg_tgl;
  logic [11:0] res_hold;
  logic res_tgl;
  logic [11:0] sar_code;
  logic decision;

  // Core domain state
  logic cfg_meta;
  logic cfg_sync;
  logic cfg_seen;
  logic res_meta;
  logic res_sync;
  logic res_seen;
  logic [7:0] cfg_core;

  // The link reset follows the core reset; it needs a few serial clocks
  always_ff @(posedge SCLK_I) begin
    link_rst_n_meta <= RESET_N_I;
    link_rst_n <= link_rst_n_meta;
  end

  // A new start bit may overlap the tail of the previous result
  // RL10 rearm at step seven
  assign allow_start = (phase == asc_pkg::ASC_PH_IDLE) || (step >= asc_pkg::STEP_REARM);
  assign byte_done = (rx_cnt == asc_pkg::RX_FULL);
  assign conv_end = (phase == asc_pkg::ASC_PH_CONVERT) && (step == asc_pkg::STEP_LAST);

  // RL1 sample on rise
  // RL25 select clears counter
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      rx_cnt <= asc_pkg::RX_IDLE;
      rx_shift <= asc_pkg::CTRL_RST;
    end else if (rx_cnt == asc_pkg::RX_IDLE) begin
      // RL2 skip leading zeros
      if (DIN_I && allow_start) begin
        rx_cnt <= asc_pkg::RX_FIRST;
        rx_shift <= {asc_pkg::CTRL_RST[6:0], DIN_I};
      end
    end else if (byte_done) begin
      rx_cnt <= asc_pkg::RX_IDLE;
    end else begin
      // RL3 MSB first
      rx_shift <= {rx_shift[6:0], DIN_I};
      rx_cnt <= rx_cnt + asc_pkg::RX_FIRST;
    end
  end

  // RL11 outputs on fall
  // RL21 start after last bit
  // RL7 byte starts conversion
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      phase <= asc_pkg::ASC_PH_IDLE;
      step <= asc_pkg::STEP_ZERO;
    end else if (byte_done) begin
      phase <= asc_pkg::ASC_PH_STROBE;
      step <= asc_pkg::STEP_ZERO;
    end else begin
      unique case (phase)
        asc_pkg::ASC_PH_IDLE: begin
          step <= asc_pkg::STEP_ZERO;
        end
        asc_pkg::ASC_PH_STROBE: begin
          phase <= asc_pkg::ASC_PH_CONVERT;
          step <= asc_pkg::STEP_ONE;
        end
        asc_pkg::ASC_PH_CONVERT: begin
          // RL23 twelve decisions
          if (step == asc_pkg::STEP_LAST) begin
            phase <= asc_pkg::ASC_PH_IDLE;
            step <= asc_pkg::STEP_ZERO;
          end else begin
            step <= step + asc_pkg::STEP_ONE;
          end
        end
        default: begin
          phase <= asc_pkg::ASC_PH_IDLE;
          step <= asc_pkg::STEP_ZERO;
        end
      endcase
    end
  end

  // RL19 bipolar MSB flip
  assign decision = (step == asc_pkg::STEP_ZERO && phase == asc_pkg::ASC_PH_STROBE &&
                     !rx_cfg_bit(cfg_hold, asc_pkg::POL_POS)) ? ~COMP_I : COMP_I;

  function automatic logic rx_cfg_bit(input logic [7:0] cfg, input int unsigned pos);
    rx_cfg_bit = cfg[pos];
  endfunction

  // RL20 MSB first on fall
  // RL17 zero, result, zeros
  // RL9 strobe before MSB
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      DOUT_O <= 1'b0;
      STROBE_O <= 1'b0;
    end else if (byte_done) begin
      DOUT_O <= 1'b0;
      STROBE_O <= (rx_shift[asc_pkg::MODE_HI_POS] && rx_shift[asc_pkg::MODE_LO_POS]);
    end else begin
      STROBE_O <= 1'b0;
      if (phase == asc_pkg::ASC_PH_STROBE) begin
        DOUT_O <= decision;
      end else if (phase == asc_pkg::ASC_PH_CONVERT && step != asc_pkg::STEP_LAST) begin
        DOUT_O <= COMP_I;
      end else begin
        DOUT_O <= 1'b0;
      end
    end
  end

  // RL24 track then hold
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      TRACK_O <= 1'b0;
    end else if (rx_cnt == asc_pkg::RX_TRACK) begin
      TRACK_O <= 1'b1;
    end else if (byte_done) begin
      TRACK_O <= 1'b0;
    end
  end

  // RL22 float when deselected
  assign DOUT_OE_O = ~CS_N_I;
  assign STROBE_OE_O = ~CS_N_I;

  // RL23 decision engine
  asc_sar u_sar (
    .clk_i(SCLK_I),
    .clr_i(CS_N_I),
    .start_i(byte_done),
    .step_i(phase != asc_pkg::ASC_PH_IDLE),
    .comp_i(COMP_I),
    .dac_code_o(DAC_CODE_O),
    .code_o(sar_code)
  );

  // Holding registers stay put for at least eight serial clocks after each
  // toggle, far longer than the three core clocks the crossing needs
  always_ff @(negedge SCLK_I) begin
    if (!link_rst_n) begin
      cfg_hold <= asc_pkg::CTRL_RST;
      cfg_tgl <= 1'b0;
      res_hold <= asc_pkg::SAR_RST;
      res_tgl <= 1'b0;
    end else begin
      if (byte_done) begin
        cfg_hold <= rx_shift;
        cfg_tgl <= ~cfg_tgl;
      end
      // RL19 twos complement
      if (conv_end) begin
        res_hold <= {sar_code[11] ^ ~cfg_hold[asc_pkg::POL_POS], sar_code[10:0]};
        res_tgl <= ~res_tgl;
      end
    end
  end

  // Toggle synchronisers; the second and third stages feed the edge detect, never the first
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      cfg_meta <= 1'b0;
      cfg_sync <= 1'b0;
      cfg_seen <= 1'b0;
      res_meta <= 1'b0;
      res_sync <= 1'b0;
      res_seen <= 1'b0;
    end else begin
      cfg_meta <= cfg_tgl;
      cfg_sync <= cfg_meta;
      cfg_seen <= cfg_sync;
      res_meta <= res_tgl;
      res_sync <= res_meta;
      res_seen <= res_sync;
    end
  end

  assign CFG_VALID_O = cfg_sync ^ cfg_seen;
  assign RESULT_VALID_O = res_sync ^ res_seen;

  // Captured configuration and result, core domain
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      cfg_core <= asc_pkg::CTRL_RST;
      RESULT_O <= '0;
      SUB_LSB_O <= '0;
    end else begin
      if (CFG_VALID_O) begin
        cfg_core <= cfg_hold;
      end
      if (RESULT_VALID_O) begin
        RESULT_O <= res_hold[11:2];
        SUB_LSB_O <= res_hold[1:0];
      end
    end
  end

  // RL5 single-ended map
  // RL6 differential pairs
  // RL8 all ones gives input seven
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      CHAN_POS_O <= '0;
      CHAN_NEG_O <= '0;
      NEG_IS_COM_O <= 1'b1;
      UNIPOLAR_O <= 1'b0;
      MODE_O <= asc_pkg::ASC_MODE_FULL_PD;
    end else begin
      CHAN_POS_O <= {cfg_core[asc_pkg::SEL_MID_POS], cfg_core[asc_pkg::SEL_LO_POS],
                     cfg_core[asc_pkg::SEL_HI_POS]};
      CHAN_NEG_O <= {cfg_core[asc_pkg::SEL_MID_POS], cfg_core[asc_pkg::SEL_LO_POS],
                     ~cfg_core[asc_pkg::SEL_HI_POS]};
      NEG_IS_COM_O <= cfg_core[asc_pkg::CFG_POS];
      UNIPOLAR_O <= cfg_core[asc_pkg::POL_POS];
      MODE_O <= {cfg_core[asc_pkg::MODE_HI_POS], cfg_core[asc_pkg::MODE_LO_POS]};
    end
  end

  // RL4 mode decode
  assign FULL_PD_O = (asc_pkg::asc_mode_t'(MODE_O) == asc_pkg::ASC_MODE_FULL_PD);
  assign FAST_PD_O = (asc_pkg::asc_mode_t'(MODE_O) == asc_pkg::ASC_MODE_FAST_PD);
  assign EXT_CLK_O = (asc_pkg::asc_mode_t'(MODE_O) == asc_pkg::ASC_MODE_EXT_CLK);

endmodule // asc_top

`default_nettype wire

// ===== design/asc_pkg.sv
// Shared constants for the serial control-byte and result interface of the
// eight-input converter. No clock or reset assumptions live here.
package asc_pkg;

  // Control byte framing
  localparam int unsigned CTRL_W = 8;
  localparam logic [3:0] RX_IDLE = 4'h0;
  localparam logic [3:0] RX_FIRST = 4'h1;
  localparam logic [3:0] RX_TRACK = 4'h5;
  localparam logic [3:0] RX_FULL = 4'h8;

  // Control byte field positions
  localparam int unsigned START_POS = 7;
  localparam int unsigned SEL_HI_POS = 6;
  localparam int unsigned SEL_MID_POS = 5;
  localparam int unsigned SEL_LO_POS = 4;
  localparam int unsigned POL_POS = 3;
  localparam int unsigned CFG_POS = 2;
  localparam int unsigned MODE_HI_POS = 1;
  localparam int unsigned MODE_LO_POS = 0;

  // Conversion sizes and step markers
  localparam int unsigned SAR_W = 12;
  localparam int unsigned RES_W = 10;
  localparam logic [3:0] STEP_ZERO = 4'h0;
  localparam logic [3:0] STEP_ONE = 4'h1;
  localparam logic [3:0] STEP_REARM = 4'h7;
  localparam logic [3:0] STEP_LAST = 4'hC;

  // Reset values and the first trial mask
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [11:0] SAR_RST = 12'h000;
  localparam logic [11:0] SAR_TOP = 12'h800;

  // Mode field decode
  typedef enum logic [1:0] {
    ASC_MODE_FULL_PD = 2'h0,
    ASC_MODE_FAST_PD = 2'h1,
    ASC_MODE_INT_CLK = 2'h2,
    ASC_MODE_EXT_CLK = 2'h3
  } asc_mode_t;

  // Link-side conversion phase, Gray along idle, strobe, convert
  typedef enum logic [1:0] {
    ASC_PH_IDLE = 2'h0,
    ASC_PH_STROBE = 2'h1,
    ASC_PH_CONVERT = 2'h3
  } asc_phase_t;

endpackage

// ===== design/asc_sar.sv
// Successive-approximation register, stepped on falling serial clock edges.
// Assumes the comparator input is settled against dac_code_o before each fall.
`timescale 1ns/1ps
`default_nettype none

module asc_sar (
  // Clock and clear
  input wire logic clk_i,
  input wire logic clr_i,
  // Control
  input wire logic start_i,
  input wire logic step_i,
  input wire logic comp_i,
  // Outputs
  output logic [11:0] dac_code_o,
  output logic [11:0] code_o
);

  logic [11:0] mask;
  logic [11:0] next_code;
  logic [11:0] next_mask;

  always_comb begin
    next_code = code_o;
    next_mask = mask;
    if (start_i) begin
      next_code = asc_pkg::SAR_RST;
      next_mask = asc_pkg::SAR_TOP;
    end else if (step_i && (mask != asc_pkg::SAR_RST)) begin
      // Keep the trial bit when the input sits at or above the trial level
      if (comp_i) begin
        next_code = code_o | mask;
      end
      next_mask = mask >> 1;
    end
  end

  // Chip select high aborts any conversion in flight
  always_ff @(negedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      code_o <= asc_pkg::SAR_RST;
      mask <= asc_pkg::SAR_RST;
      dac_code_o <= asc_pkg::SAR_RST;
    end else begin
      code_o <= next_code;
      mask <= next_mask;
      dac_code_o <= next_code | next_mask;
    end
  end

endmodule // asc_sar

`default_nettype wire

// ===== test/asc_top_assertions.sv
// Concurrent checks on the serial link and core outputs of asc_top.
// Assumes SCLK_I idles low between frames and CS_N_I high clears the link side.
`timescale 1ns/1ps
`default_nettype none

module asc_top_checker (
  // Clocks and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SCLK_I,
  // Serial link
  input wire logic CS_N_I,
  input wire logic DOUT_O,
  input wire logic DOUT_OE_O,
  input wire logic STROBE_O,
  input wire logic STROBE_OE_O,
  input wire logic TRACK_O,
  input wire logic [11:0] DAC_CODE_O,
  // Core side
  input wire logic [1:0] MODE_O,
  input wire logic FULL_PD_O,
  input wire logic FAST_PD_O,
  input wire logic EXT_CLK_O
);
  // Output levels seen at each rise; a change before the next fall breaks the rule
  logic dout_at_rise;
  logic strobe_at_rise;

  always_ff @(posedge SCLK_I) begin
    dout_at_rise <= DOUT_O;
    strobe_at_rise <= STROBE_O;
  end

  a_strobe_one_period: assert property (@(negedge SCLK_I) disable iff (CS_N_I || !RESET_N_I)
    $rose(STROBE_O) |=> !STROBE_O) else $error("strobe longer than one serial clock");
  a_dac_first_trial: assert property (@(negedge SCLK_I) disable iff (CS_N_I || !RESET_N_I)
    $rose(STROBE_O) |-> DAC_CODE_O == 12'h800 && !DOUT_O) else $error("first trial code wrong");
  a_track_hold_span: assert property (@(negedge SCLK_I) disable iff (CS_N_I || !RESET_N_I)
    $rose(TRACK_O) |-> TRACK_O [*3] ##1 !TRACK_O) else $error("tracking span not three clocks");
  a_trailing_zero_bits: assert property (@(negedge SCLK_I) disable iff (CS_N_I || !RESET_N_I)
    $fell(STROBE_O) |-> ##12 (!DOUT_O) [*3]) else $error("data not zero after twelve decisions");
  a_oe_follows_select: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    DOUT_OE_O == !CS_N_I && STROBE_OE_O == !CS_N_I) else $error("output enable not tied to select");
  a_idle_outputs_low: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    CS_N_I |-> !DOUT_O && !STROBE_O && !TRACK_O) else $error("link outputs active while deselected");
  a_fall_edge_only: assert property (@(negedge SCLK_I) disable iff (!RESET_N_I || CS_N_I)
    DOUT_O == dout_at_rise && STROBE_O == strobe_at_rise) else $error("output moved on high clock");
  a_mode_decode_map: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    FULL_PD_O == (MODE_O == 2'h0) && FAST_PD_O == (MODE_O == 2'h1) && EXT_CLK_O == (MODE_O == 2'h3))
    else $error("mode decode wrong");
endmodule // asc_top_checker

bind asc_top asc_top_checker chk_u (.CORE_CLK_I, .RESET_N_I, .SCLK_I, .CS_N_I, .DOUT_O, .DOUT_OE_O,
  .STROBE_O, .STROBE_OE_O, .TRACK_O, .DAC_CODE_O, .MODE_O, .FULL_PD_O, .FAST_PD_O, .EXT_CLK_O);

`default_nettype wire

// ===== test/asc_master.sv
// Serial bus master model: clock idles low, data changes after falls, sampled on rises.
// Assumes the bench calls its tasks one at a time; half period is 15 ns.
`timescale 1ns/1ps
`default_nettype none

module asc_master (
  // Serial link
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic din_o,
  input wire logic dout_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic tick(input logic b, output logic got);
    din_o = b;
    #15 sclk_o = 1'b1;
    got = dout_i;
    #15 sclk_o = 1'b0;
  endtask

  // Deselected data line keeps moving so a stale level is never trusted
  task automatic idle(input int n);
    logic got;
    for (int i = 0; i < n; i++)
      tick(~din_o, got);
  endtask

  task automatic frame(input logic [7:0] ctrl, input int lead, input int n, input logic fill,
                       output logic [23:0] rx);
    logic got;
    rx = 24'h000000;
    cs_n_o = 1'b0;
    #15;
    for (int i = 0; i < lead; i++)
      tick(1'b0, got);
    for (int i = 0; i < n; i++) begin
      tick(i < 8 ? ctrl[7 - i] : fill, got);
      rx = {rx[22:0], got};
    end
    #15 cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule // asc_master

`default_nettype wire

// ===== test/asc_top_tb.sv
// Testbench for asc_top: serial frames from a master model, checks on bytes and core outputs.
// Assumes comparator decides input level against the trial code.
`timescale 1ns/1ps
`default_nettype none

module asc_top_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, din, dout, dout_oe, strobe, strobe_oe, comp, track, cfg_valid, neg_com, unipolar;
  logic full_pd, fast_pd, ext_clk, res_valid;
  logic [11:0] dac;
  logic [11:0] level = 12'h000;
  logic [2:0] chan_pos, chan_neg;
  logic [1:0] mode, sub_lsb;
  logic [9:0] result;
  logic [23:0] rx;
  int n_mismatch = 0;
  int check_count = 0;
  int n_res = 0;
  int n_cfg = 0;
  int n_rise = 0;
  int sq[$];
  int r0, g0;

  always #10 core_clk = ~core_clk;
  assign comp = (level >= dac);

  asc_master master_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
  asc_top dut_u (.CORE_CLK_I(core_clk), .RESET_N_I(reset_n), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .STROBE_O(strobe), .STROBE_OE_O(strobe_oe), .COMP_I(comp),
    .TRACK_O(track), .DAC_CODE_O(dac), .CFG_VALID_O(cfg_valid), .CHAN_POS_O(chan_pos),
    .CHAN_NEG_O(chan_neg), .NEG_IS_COM_O(neg_com), .UNIPOLAR_O(unipolar), .MODE_O(mode),
    .FULL_PD_O(full_pd), .FAST_PD_O(fast_pd), .EXT_CLK_O(ext_clk), .RESULT_VALID_O(res_valid),
    .RESULT_O(result), .SUB_LSB_O(sub_lsb));

  always @(posedge core_clk) begin
    n_res += (res_valid === 1'b1);
    n_cfg += (cfg_valid === 1'b1);
  end
  always @(posedge sclk) begin
    n_rise++;
    if (strobe === 1'b1)
      sq.push_back(n_rise);
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conv(input logic [7:0] ctrl, input int lead, input logic [11:0] lv);
    logic [11:0] d;
    logic [2:0] pos;
    int r;
    level = lv;
    r = n_res;
    d = ctrl[3] ? lv : lv ^ 12'h800;
    pos = {ctrl[5:4], ctrl[6]};
    master_u.frame(ctrl, lead, 24, 1'b0, rx);
    repeat (8) @(posedge core_clk);
    check(rx, {9'h000, d, 3'h0});
    check(n_res - r, 1);
    check({result, sub_lsb}, d);
    check(chan_pos, pos);
    check(neg_com, ctrl[2]);
    if (ctrl[2] == 1'b0)
      check(chan_neg, pos ^ 3'h1);
    check({unipolar, mode}, {ctrl[3], ctrl[1:0]});
    check({full_pd, fast_pd, ext_clk}, {ctrl[1:0] == 2'h0, ctrl[1:0] == 2'h1, ctrl[1:0] == 2'h3});
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    fork
      master_u.idle(8);
      repeat (8) @(posedge core_clk);
    join
    @(posedge core_clk) reset_n <= 1'b1;
    master_u.idle(4);
    for (int c = 0; c < 8; c++)
      conv({1'b1, 3'(c), 4'hF}, c, 12'(4095 - c * 585));
    $display("Done: single-ended sweep");
    for (int c = 0; c < 8; c++)
      conv({1'b1, 3'(c), 2'h0, 2'(c)}, 0, 12'(4095 - c * 585));
    $display("Done: differential and modes");
    level = 12'hABC;
    r0 = n_res;
    sq.delete();
    master_u.frame(8'hFF, 0, 39, 1'b1, rx);
    repeat (8) @(posedge core_clk);
    check(sq.size(), 3);
    check(sq[2] - sq[1], 15);
    check(sq[1] - sq[0], 15);
    check(n_res - r0, 2);
    check({chan_pos, neg_com, unipolar, mode, result}, {3'h7, 1'b1, 1'b1, 2'h3, 10'h2AF});
    $display("Done: data held high");
    r0 = n_res;
    g0 = n_cfg;
    master_u.frame(8'h00, 0, 24, 1'b0, rx);
    master_u.frame(8'h8F, 0, 14, 1'b0, rx);
    repeat (8) @(posedge core_clk);
    check(n_res - r0, 0);
    check(n_cfg - g0, 1);
    conv(8'hF7, 3, 12'h7FF);
    $display("Done: abort and restart");
    stop_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule // asc_top_tb

`default_nettype wire
